// [rtl/rtcmap_alarm_cmp.sv]
`timescale 1ns/100ps
`include "rtcmap_consts.svh"
module rtcmap_alarm_cmp
  import rtcmap_pkg::*;
(
  input wire logic [7:0] time_sec,
  input wire logic [7:0] time_min,
  input wire logic [7:0] time_hour,
  input wire logic [7:0] alarm_sec,
  input wire logic [7:0] alarm_min,
  input wire logic [7:0] alarm_hour,
  output logic match
);
  function automatic logic rtcmap_hit(input logic [7:0] t,
                                      input logic [7:0] a);
    rtcmap_hit = ((a & `RTCMAP_WILD_MASK) == `RTCMAP_WILD_MASK) // R07
      || (a == t);
  endfunction

  assign match = rtcmap_hit(time_sec, alarm_sec)
    && rtcmap_hit(time_min, alarm_min)
    && rtcmap_hit(time_hour, alarm_hour);
endmodule

// [rtl/rtcmap_regs.sv]
`timescale 1ns/100ps
`include "rtcmap_consts.svh"
// Functional notes
// R01: Clear binary select means packed BCD bytes.
// R02: Set binary select means plain binary bytes.
// R03: Time bytes undefined until software writes.
// R04: Written ones in zero bits accepted; seconds bit 7 is cleared instead.
// R05: Software writes zeros into zero bits.
// R06: Hours top bit marks afternoon in 12h.
// R07: Alarm byte C0-FF matches any value.
// R08: Control bytes both banks; extended bank-only.
// R09: Writes to status bytes ignored.
module rtcmap_regs
  import rtcmap_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic alarm_match,
  output logic afternoon_flag,
  output logic binary_format_select
);
  rtcmap_byte_t time_seconds_reg, alarm_seconds_reg, time_minutes_reg;
  rtcmap_byte_t alarm_minutes_reg, time_hours_reg, alarm_hours_reg;
  rtcmap_byte_t day_of_week_reg, day_of_month_reg, month_of_year_reg;
  rtcmap_byte_t year_in_century_reg, divider_rate_control_reg;
  rtcmap_byte_t interrupt_format_control_reg, century_count_reg;
  rtcmap_byte_t alarm_day_of_month_reg;
  rtcmap_bus_e bus_state_reg;
  logic aw_held_reg, w_held_reg;
  logic [9:0] awaddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic [1:0] bresp_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire, rd_fire, wr_ok;
  logic [7:0] rd_byte;
  logic rd_ok;

  function automatic logic rtcmap_mapped(input logic [9:0] a,
                                         input logic bank);
    logic [7:0] off;
    off = a[9:2];
    if (a[1:0] != 2'h0) begin
      rtcmap_mapped = 1'b0;
    end else if (off <= `RTCMAP_OFF_STD) begin
      rtcmap_mapped = 1'b1; // R08
    end else begin
      rtcmap_mapped = bank && ((off == `RTCMAP_OFF_CENT) ||
        (off == `RTCMAP_OFF_ADOM)); // R08
    end
  endfunction

  function automatic logic rtcmap_hit_off(input logic [9:0] a,
                                          input logic [7:0] off);
    rtcmap_hit_off = (a[9:2] == off);
  endfunction

  // Bank select lives in the divider control byte
  logic bank_select;
  assign bank_select = divider_rate_control_reg[`RTCMAP_BIT_BANK]; // R08
  assign binary_format_select =
    interrupt_format_control_reg[`RTCMAP_BIT_BINARY]; // R01 R02
  assign afternoon_flag =
    !interrupt_format_control_reg[`RTCMAP_BIT_H24]
    && time_hours_reg[`RTCMAP_BIT_PM]; // R06

  rtcmap_alarm_cmp u_cmp (
    .time_sec(time_seconds_reg),
    .time_min(time_minutes_reg),
    .time_hour(time_hours_reg),
    .alarm_sec(alarm_seconds_reg),
    .alarm_min(alarm_minutes_reg),
    .alarm_hour(alarm_hours_reg),
    .match(alarm_match)
  );

  assign s_axi_awready = (bus_state_reg == RTCMAP_IDLE) && !aw_held_reg;
  assign s_axi_wready = (bus_state_reg == RTCMAP_IDLE) && !w_held_reg;
  assign s_axi_arready = (bus_state_reg == RTCMAP_IDLE)
    && !aw_held_reg && !w_held_reg && !s_axi_awvalid && !s_axi_wvalid;
  assign s_axi_bvalid = (bus_state_reg == RTCMAP_WRESP);
  assign s_axi_rvalid = (bus_state_reg == RTCMAP_RDATA);
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  assign wr_fire = (bus_state_reg == RTCMAP_IDLE)
    && aw_held_reg && w_held_reg;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_ok = rtcmap_mapped(awaddr_reg, bank_select);

  // Address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wbyte_reg <= s_axi_wdata[7:0];
      wlane_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_state_reg <= RTCMAP_IDLE;
      bresp_reg <= `RTCMAP_RESP_OK;
    end else begin
      unique case (bus_state_reg)
        RTCMAP_IDLE: begin
          if (wr_fire) begin
            bus_state_reg <= RTCMAP_WRESP;
            bresp_reg <= wr_ok ? `RTCMAP_RESP_OK : `RTCMAP_RESP_SLVERR;
          end else if (rd_fire) begin
            bus_state_reg <= RTCMAP_RDATA;
          end
        end
        RTCMAP_WRESP: begin
          if (s_axi_bready) begin
            bus_state_reg <= RTCMAP_IDLE;
          end
        end
        RTCMAP_RDATA: begin
          if (s_axi_rready) begin
            bus_state_reg <= RTCMAP_IDLE;
          end
        end
      endcase
    end
  end

  // Time bytes keep no reset value; control bytes do
  logic do_wr;
  logic wr_status;
  // Status bytes answer OKAY but never store
  assign wr_status = rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_STC)
    || rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_STD); // R09
  assign do_wr = wr_fire && wr_ok && wlane_reg
    && !wr_status;

  // Bits shown as zero are stored as written, except seconds bit 7, which is cleared
  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_SEC)) begin // R03
      time_seconds_reg <= wbyte_reg & ~`RTCMAP_SEC_RO_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_ASEC)) begin
      alarm_seconds_reg <= wbyte_reg; // R07
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_MIN)) begin
      time_minutes_reg <= wbyte_reg; // R04
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_AMIN)) begin
      alarm_minutes_reg <= wbyte_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_HOUR)) begin
      time_hours_reg <= wbyte_reg; // R04
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_AHOUR)) begin
      alarm_hours_reg <= wbyte_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_DOW)) begin
      day_of_week_reg <= wbyte_reg; // R04
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_DOM)) begin
      day_of_month_reg <= wbyte_reg; // R04
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_MON)) begin
      month_of_year_reg <= wbyte_reg; // R04
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_YEAR)) begin
      year_in_century_reg <= wbyte_reg; // R04
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_CENT)) begin
      century_count_reg <= wbyte_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_ADOM)) begin
      alarm_day_of_month_reg <= wbyte_reg;
    end
  end

  // Control bytes reset to known values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divider_rate_control_reg <= `RTCMAP_CTLA_RESET;
    end else if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_CTLA)) begin
      divider_rate_control_reg <= wbyte_reg & `RTCMAP_CTLA_WMASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_format_control_reg <= `RTCMAP_CTLB_RESET;
    end else if (do_wr && rtcmap_hit_off(awaddr_reg, `RTCMAP_OFF_CTLB)) begin
      interrupt_format_control_reg <= wbyte_reg;
      if (wbyte_reg[`RTCMAP_BIT_SET]) begin
        interrupt_format_control_reg[`RTCMAP_BIT_UIE] <= 1'b0;
      end
    end
  end

  // Read mux
  always_comb begin
    rd_ok = rtcmap_mapped(s_axi_araddr, bank_select);
    unique case (s_axi_araddr[9:2])
      `RTCMAP_OFF_SEC: rd_byte = time_seconds_reg;
      `RTCMAP_OFF_ASEC: rd_byte = alarm_seconds_reg;
      `RTCMAP_OFF_MIN: rd_byte = time_minutes_reg;
      `RTCMAP_OFF_AMIN: rd_byte = alarm_minutes_reg;
      `RTCMAP_OFF_HOUR: rd_byte = time_hours_reg;
      `RTCMAP_OFF_AHOUR: rd_byte = alarm_hours_reg;
      `RTCMAP_OFF_DOW: rd_byte = day_of_week_reg;
      `RTCMAP_OFF_DOM: rd_byte = day_of_month_reg;
      `RTCMAP_OFF_MON: rd_byte = month_of_year_reg;
      `RTCMAP_OFF_YEAR: rd_byte = year_in_century_reg;
      `RTCMAP_OFF_CTLA: rd_byte = divider_rate_control_reg;
      `RTCMAP_OFF_CTLB: rd_byte = interrupt_format_control_reg;
      `RTCMAP_OFF_STC: rd_byte = {alarm_match, 3'h0, 4'h0}
        & `RTCMAP_STC_MASK;
      `RTCMAP_OFF_STD: rd_byte = `RTCMAP_BATT_GOOD;
      `RTCMAP_OFF_CENT: rd_byte = century_count_reg;
      `RTCMAP_OFF_ADOM: rd_byte = alarm_day_of_month_reg;
      default: rd_byte = 8'h00;
    endcase
    if (!rd_ok) begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RTCMAP_RESP_OK;
    end else if (rd_fire) begin
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_ok ? `RTCMAP_RESP_OK : `RTCMAP_RESP_SLVERR;
    end
  end
endmodule

// [shared/rtcmap_consts.svh]
`ifndef RTCMAP_CONSTS_SVH
`define RTCMAP_CONSTS_SVH

`define RTCMAP_OFF_SEC 8'h00
`define RTCMAP_OFF_ASEC 8'h01
`define RTCMAP_OFF_MIN 8'h02
`define RTCMAP_OFF_AMIN 8'h03
`define RTCMAP_OFF_HOUR 8'h04
`define RTCMAP_OFF_AHOUR 8'h05
`define RTCMAP_OFF_DOW 8'h06
`define RTCMAP_OFF_DOM 8'h07
`define RTCMAP_OFF_MON 8'h08
`define RTCMAP_OFF_YEAR 8'h09
`define RTCMAP_OFF_CTLA 8'h0A
`define RTCMAP_OFF_CTLB 8'h0B
`define RTCMAP_OFF_STC 8'h0C
`define RTCMAP_OFF_STD 8'h0D
`define RTCMAP_OFF_CENT 8'h48
`define RTCMAP_OFF_ADOM 8'h49
`define RTCMAP_ADDR_W 10
`define RTCMAP_BIT_SET 7
`define RTCMAP_BIT_UIE 4
`define RTCMAP_BIT_BINARY 2
`define RTCMAP_BIT_H24 1
`define RTCMAP_BIT_BANK 4
`define RTCMAP_BIT_OSC 5
`define RTCMAP_BIT_HOLD 6
`define RTCMAP_BIT_PM 7
`define RTCMAP_CTLA_WMASK 8'h7F
`define RTCMAP_STC_MASK 8'hF0
`define RTCMAP_WILD_MASK 8'hC0
`define RTCMAP_BATT_GOOD 8'h80
`define RTCMAP_CTLA_RESET 8'h20
`define RTCMAP_CTLB_RESET 8'h00
`define RTCMAP_SEC_RO_MASK 8'h80
`define RTCMAP_RESP_OK 2'h0
`define RTCMAP_RESP_SLVERR 2'h2
`define RTCMAP_TICK_CYCLES 28'h0BEBC20

`endif

// [shared/rtcmap_pkg.sv]
package rtcmap_pkg;
  typedef logic [7:0] rtcmap_byte_t;
  typedef enum logic [2:0] {
    RTCMAP_IDLE = 3'b001,
    RTCMAP_WRESP = 3'b010,
    RTCMAP_RDATA = 3'b100
  } rtcmap_bus_e;
endpackage

// [tb/rtcmap_checker.sv]
`timescale 1ns/100ps
`include "rtcmap_consts.svh"
module rtcmap_checker
  import rtcmap_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic alarm_match,
  input wire logic afternoon_flag,
  input wire logic binary_format_select
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic ar;
  logic wa;
  logic [7:0] ao;
  assign ar = s_axi_arvalid && s_axi_arready;
  assign ao = s_axi_araddr[9:2];
  assign wa = s_axi_bvalid || (s_axi_wvalid && s_axi_wready)
    || (s_axi_awvalid && s_axi_awready);
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no bvalid");
  chk_read_resp: assert property (ar |=> s_axi_rvalid) else $error("no rvalid");
  chk_ar_block: assert property (s_axi_awvalid || s_axi_wvalid
    |-> !s_axi_arready) else $error("read beside write");
  chk_bad_addr: assert property (ar && (s_axi_araddr[1:0] != 2'h0
    || ao > 8'h49 || (ao > 8'h0D && ao < 8'h48)) |=> s_axi_rdata == 32'h0
    && s_axi_rresp == `RTCMAP_RESP_SLVERR) else $error("bad addr accepted");
  chk_status_read: assert property (ar && s_axi_araddr == 10'h034 |=>
    s_axi_rdata == 32'h80) else $error("status byte wrong");
  chk_fmt_write: assert property ($changed(binary_format_select) |->
    wa || $past(wa)) else $error("format moved alone");
  chk_pm_write: assert property ($changed(afternoon_flag) |->
    wa || $past(wa)) else $error("pm moved alone");
  chk_match_write: assert property ($changed(alarm_match) |->
    wa || $past(wa)) else $error("match moved alone");
endmodule
bind rtcmap_regs rtcmap_checker chk_u (.*);

// [tb/rtcmap_host.sv]
`timescale 1ns/100ps
module rtcmap_host (
  input wire logic aclk,
  output logic [9:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [9:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 22'h0;
    {s_axi_wdata, s_axi_wstrb} = 36'hF;
  end
  // Released address and data lines flip so stale values never match
  task automatic wr(input logic [7:0] o, d, output logic [1:0] r,
    input logic [3:0] b = 4'hF);
    @(posedge aclk);
    s_axi_awaddr <= {o, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= b;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] o, output logic [31:0] q,
    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {o, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~s_axi_araddr;
      end
    end while (!s_axi_rvalid);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
`include "rtcmap_consts.svh"
module tb;
  logic aclk, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, alarm_match, afternoon_flag;
  logic binary_format_select, aresetn = 1'b0;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] o, sd = 8'h38;
  logic [7:0] bo [4] = '{8'h00, 8'h07, 8'h09, 8'h48};
  logic [7:0] bv [2][4] = '{'{8'h59, 8'h31, 8'h99, 8'h99},
    '{8'h3B, 8'h1F, 8'h63, 8'h63}};
  logic [15:0] pre [5] = '{16'h0015, 16'h0230, 16'h0405, 16'h03C0, 16'h05FF};
  logic [7:0] av [3] = '{8'h16, 8'hC7, 8'h15};
  localparam logic [1:0] okr = `RTCMAP_RESP_OK;
  localparam logic [1:0] ser = `RTCMAP_RESP_SLVERR;
  int fails = 0, checks = 0, cyc = 0, i, m;
  rtcmap_regs dut_u (.*);
  rtcmap_host host_u (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] expb(input logic [7:0] a, d);
    return a == 8'h00 ? d & 8'h7F : d;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wc(input logic [7:0] a, d, input logic [1:0] e);
    host_u.wr(a, d, r);
    chk("bresp", {30'h0, e}, {30'h0, r});
  endtask
  task automatic rc(input logic [7:0] a, d, input logic [1:0] e);
    host_u.rd(a, q, r);
    chk("rresp", {30'h0, e}, {30'h0, r});
    chk("rdata", {24'h0, d}, q);
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h0A, 8'h20, okr);
    rc(8'h0B, 8'h00, okr);
    rc(8'h48, 8'h00, ser);
    wc(8'h49, 8'h11, ser);
    rc(8'h20, 8'h00, ser);
    wc(8'h0D, 8'h00, okr);
    wc(8'h0C, 8'hFF, okr);
    rc(8'h0D, 8'h80, okr);
    wc(8'h0A, 8'hB0, okr);
    rc(8'h0A, 8'h30, okr);
    for (m = 0; m < 2; m++) begin
      wc(8'h0B, m ? 8'h04 : 8'h00, okr);
      chk("binary", m, binary_format_select);
      wc(8'h04, m ? 8'h8B : 8'h91, okr);
      chk("pm", 1, afternoon_flag);
      for (i = 0; i < 4; i++) begin
        wc(bo[i], bv[m][i], okr);
        rc(bo[i], bv[m][i], okr);
      end
    end
    wc(8'h0B, 8'h02, okr);
    chk("pm", 0, afternoon_flag);
    for (i = 0; i < 16; i++) begin
      sd = nx(sd);
      o = sd[3:0] < 4'hA ? {4'h0, sd[3:0]} : 8'h49;
      sd = nx(sd);
      wc(o, sd, okr);
      rc(o, expb(o, sd), okr);
    end
    foreach (pre[k]) wc(pre[k][15:8], pre[k][7:0], okr);
    host_u.wr(8'h00, 8'h77, r, 4'h0);
    chk("bresp", {30'h0, okr}, {30'h0, r});
    rc(8'h00, 8'h15, okr);
    for (i = 0; i < 3; i++) begin
      wc(8'h01, av[i], okr);
      chk("match", i > 0, alarm_match);
      rc(8'h0C, i > 0 ? 8'h80 : 8'h00, okr);
    end
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h0A, 8'h20, okr);
    wrap_up;
  end
endmodule
